// ### psm_regs.vh
// object indices, field positions, reset values and timing counts of the positioning option block
`ifndef PSM_REGS_VH
`define PSM_REGS_VH
`define PSM_IDX_CONTROL_WORD 16'h6040
`define PSM_IDX_STATUS_WORD 16'h6041
`define PSM_IDX_SLIP_TIME 16'h203f
`define PSM_IDX_OPTION_WORD 16'h60f2
`define PSM_IDX_FOLLOW_ERR 16'h60f4
`define PSM_IDX_SLIP_LIMIT 16'h60f8
`define PSM_IDX_CORRECTION 16'h60fa
`define PSM_RST_OPTION_WORD 16'h0001
`define PSM_RST_SLIP_LIMIT 32'h00000190
`define PSM_RST_SLIP_TIME 16'h0064
`define PSM_RST_ZERO32 32'h00000000
`define PSM_SLIP_OFF_VALUE 32'h7fffffff
`define PSM_REL_SEL_LSB 0
`define PSM_HS_SEL_LSB 4
`define PSM_DIR_SEL_LSB 6
`define PSM_CW_NEW_SETPOINT 4
`define PSM_CW_RELATIVE 6
`define PSM_SW_TARGET_REACHED 10
`define PSM_SW_SETPOINT_ACK 12
`define PSM_SW_SLIPPAGE 13
`define PSM_SLIP_TIME_UNIT_NS 1000000
`define PSM_CLK_PERIOD_NS 10
`define PSM_TICK_CYCLES (`PSM_SLIP_TIME_UNIT_NS / `PSM_CLK_PERIOD_NS)
`endif

// ### psm_slip_monitor.v
// slippage supervision: speed deviation against limit, held for a time in milliseconds
`timescale 1ns/1ps
`include "psm_regs.vh"
module psm_slip_monitor
#(
  parameter TICK_CYCLES = `PSM_TICK_CYCLES
)
(
  // clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // speeds and settings
  input wire [31:0] actual_speed_i,
  input wire [31:0] set_speed_i,
  input wire [31:0] slip_limit_i,
  input wire [15:0] slip_time_i,
  // result
  output reg slip_o,
  output reg slip_rise_o
);
  reg [31:0] tick_cnt;
  reg tick;
  reg [16:0] ms_cnt;
  wire signed [32:0] diff = $signed({actual_speed_i[31], actual_speed_i}) - $signed({set_speed_i[31], set_speed_i});
  wire [32:0] abs_diff = diff[32] ? (33'h000000000 - diff) : diff;
  wire [32:0] abs_limit = slip_limit_i[31] ? (33'h000000000 - {1'b1, slip_limit_i}) : {1'b0, slip_limit_i};
  wire mon_on = (slip_limit_i != `PSM_SLIP_OFF_VALUE);
  wire excess = mon_on && (abs_diff > abs_limit);

  // millisecond enable; ms count restarts whenever the deviation is back in bounds
  always @(posedge clk_sys_i)
  begin
    if (rst_i || tick_cnt == TICK_CYCLES - 1)
      tick_cnt <= 32'h00000000;
    else
      tick_cnt <= tick_cnt + 32'h00000001;
    tick <= !rst_i && (tick_cnt == TICK_CYCLES - 1);
  end

  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ms_cnt <= 17'h00000;
      slip_o <= 1'b0;
      slip_rise_o <= 1'b0;
    end
    else
    begin
      slip_rise_o <= 1'b0;
      if (!excess)
      begin
        ms_cnt <= 17'h00000;
        slip_o <= 1'b0;
      end
      else
      begin
        if (tick && !ms_cnt[16])
          ms_cnt <= ms_cnt + 17'h00001;
        // strictly longer than the time: one tick past the setting
        if (ms_cnt > {1'b0, slip_time_i} && !slip_o)
        begin
          slip_o <= 1'b1;
          slip_rise_o <= 1'b1;
        end
      end
    end
  end
endmodule // psm_slip_monitor

// ### psm_option_core.v
// profile position option decoding, setpoint handshake, rotary direction and slippage flag
`timescale 1ns/1ps
`include "psm_regs.vh"
// Notes on behaviour
// - code 00: relative to previous target
// - code 01: relative to ramp output
// - code 10: relative to actual position
// - reference used only for relative moves
// - release codes 01 and 10: drive clears new-setpoint bit
// - code 01: release when target reached
// - code 10: release as soon as possible
// - code 00: linear, no wrap at limits
// - code 01: negative only, via minimum
// - code 10: positive only, via maximum
// - code 11: shortest path, positive below half
// - following error readable, signed
// - excess deviation sets slippage status bit
// - only after deviation outlasts slippage time
// - limit at maximum disables monitoring
// - configured reaction logs an error entry
// - correction speed readable, signed
module psm_option_core
#(
  parameter TICK_CYCLES = `PSM_TICK_CYCLES
)
(
  // clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // object access from the fieldbus master
  input wire obj_wr_i,
  input wire obj_rd_i,
  input wire [15:0] obj_index_i,
  input wire [31:0] obj_wdata_i,
  output reg [31:0] obj_rdata_o,
  output reg obj_ack_o,
  output reg obj_err_o,
  // drive state
  input wire [31:0] target_pos_i,
  input wire [31:0] ramp_out_i,
  input wire [31:0] actual_pos_i,
  input wire [31:0] range_min_i,
  input wire [31:0] range_max_i,
  input wire setpoint_accept_i,
  input wire target_reached_i,
  input wire [31:0] actual_speed_i,
  input wire [31:0] set_speed_i,
  input wire [31:0] following_error_i,
  input wire [31:0] correction_speed_i,
  input wire slip_reaction_en_i,
  // move command to the profile generator
  output reg [31:0] abs_target_o,
  output reg move_start_o,
  output reg [1:0] move_dir_o,
  output reg via_limit_o,
  // words and events
  output reg [15:0] control_word_o,
  output reg [15:0] status_word_o,
  output reg error_log_o
);
  localparam DIR_POS = 2'b01;
  localparam DIR_NEG = 2'b10;

  reg [15:0] option_word;
  reg [31:0] slip_limit;
  reg [15:0] slip_time;
  reg [31:0] follow_err;
  reg [31:0] correction;
  reg [31:0] prev_target;
  reg setpoint_ack;
  reg move_active;
  reg new_sp_q;
  wire slip_flag;
  wire slip_rise;

  wire [1:0] rel_sel = option_word[`PSM_REL_SEL_LSB +: 2];
  wire [1:0] hs_sel = option_word[`PSM_HS_SEL_LSB +: 2];
  wire [1:0] dir_sel = option_word[`PSM_DIR_SEL_LSB +: 2];
  wire new_sp = control_word_o[`PSM_CW_NEW_SETPOINT];
  wire [31:0] range_span = range_max_i - range_min_i + 32'h00000001;

  // folds a position that left the range back in from the opposite limit
  function [31:0] wrap_pos;
    input [31:0] p;
    input [31:0] lo;
    input [31:0] hi;
    input [31:0] span;
    begin
      if ($signed(p) > $signed(hi))
        wrap_pos = p - span;
      else if ($signed(p) < $signed(lo))
        wrap_pos = p + span;
      else
        wrap_pos = p;
    end
  endfunction

  // base of a relative move
  reg [31:0] rel_base;
  always @*
  begin
    case (rel_sel)
      2'b00: rel_base = prev_target;
      2'b01: rel_base = ramp_out_i;
      2'b10: rel_base = actual_pos_i;
      default: rel_base = prev_target; // reserved code, treated as 00
    endcase
  end

  wire is_relative = control_word_o[`PSM_CW_RELATIVE];
  wire [31:0] raw_target = is_relative ? (rel_base + target_pos_i) : target_pos_i;

  // linear mode keeps the full sum so moves beyond one turn survive
  reg [31:0] next_target;
  reg [1:0] next_dir;
  reg next_via;
  reg [31:0] fwd_dist;
  always @*
  begin
    next_target = wrap_pos(raw_target, range_min_i, range_max_i, range_span);
    fwd_dist = next_target - actual_pos_i;
    if ($signed(fwd_dist) < 0)
      fwd_dist = fwd_dist + range_span;
    next_via = 1'b0;
    case (dir_sel)
      2'b00:
      begin
        // flag the pass through a limit before the wrapped value is dropped
        next_via = (next_target != raw_target);
        next_target = raw_target;
        next_dir = ($signed(raw_target) >= $signed(actual_pos_i)) ? DIR_POS : DIR_NEG;
      end
      2'b01:
      begin
        next_dir = DIR_NEG;
        next_via = ($signed(next_target) > $signed(actual_pos_i));
      end
      2'b10:
      begin
        next_dir = DIR_POS;
        next_via = ($signed(next_target) < $signed(actual_pos_i));
      end
      default:
      begin
        next_dir = (fwd_dist < {1'b0, range_span[31:1]}) ? DIR_POS : DIR_NEG;
        next_via = (next_dir == DIR_POS) ? ($signed(next_target) < $signed(actual_pos_i))
                                         : ($signed(next_target) > $signed(actual_pos_i));
      end
    endcase
  end

  wire take_sp = new_sp && !new_sp_q && !setpoint_ack && setpoint_accept_i;
  wire wr_cw = obj_wr_i && (obj_index_i == `PSM_IDX_CONTROL_WORD);

  // drive release of the new-setpoint bit; a master write in the same cycle wins
  reg drive_release;
  always @*
  begin
    case (hs_sel)
      2'b01: drive_release = setpoint_ack && move_active && target_reached_i;
      2'b10: drive_release = setpoint_ack;
      default: drive_release = 1'b0;
    endcase
  end

  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      control_word_o <= 16'h0000;
      new_sp_q <= 1'b0;
      setpoint_ack <= 1'b0;
      move_active <= 1'b0;
      prev_target <= `PSM_RST_ZERO32;
      abs_target_o <= `PSM_RST_ZERO32;
      move_start_o <= 1'b0;
      move_dir_o <= 2'b00;
      via_limit_o <= 1'b0;
    end
    else
    begin
      new_sp_q <= new_sp;
      move_start_o <= take_sp;
      if (wr_cw)
        control_word_o <= obj_wdata_i[15:0];
      else if (drive_release)
        control_word_o[`PSM_CW_NEW_SETPOINT] <= 1'b0;
      if (take_sp)
      begin
        abs_target_o <= next_target;
        prev_target <= next_target;
        move_dir_o <= next_dir;
        via_limit_o <= next_via;
        setpoint_ack <= 1'b1;
      end
      else if (!new_sp)
        setpoint_ack <= 1'b0;
      if (take_sp)
        move_active <= 1'b1;
      else if (target_reached_i)
        move_active <= 1'b0;
    end
  end

  // configuration writes
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      option_word <= `PSM_RST_OPTION_WORD;
      slip_limit <= `PSM_RST_SLIP_LIMIT;
      slip_time <= `PSM_RST_SLIP_TIME;
    end
    else if (obj_wr_i)
    begin
      if (obj_index_i == `PSM_IDX_OPTION_WORD)
        option_word <= obj_wdata_i[15:0];
      if (obj_index_i == `PSM_IDX_SLIP_LIMIT)
        slip_limit <= obj_wdata_i;
      if (obj_index_i == `PSM_IDX_SLIP_TIME)
        slip_time <= obj_wdata_i[15:0];
    end
  end

  // live values are sampled every cycle so a read never tears
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      follow_err <= `PSM_RST_ZERO32;
      correction <= `PSM_RST_ZERO32;
    end
    else
    begin
      follow_err <= following_error_i;
      correction <= correction_speed_i;
    end
  end

  psm_slip_monitor #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_slip (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .actual_speed_i(actual_speed_i),
    .set_speed_i(set_speed_i),
    .slip_limit_i(slip_limit),
    .slip_time_i(slip_time),
    .slip_o(slip_flag),
    .slip_rise_o(slip_rise)
  );

  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      status_word_o <= 16'h0000;
      error_log_o <= 1'b0;
    end
    else
    begin
      status_word_o <= 16'h0000;
      status_word_o[`PSM_SW_SLIPPAGE] <= slip_flag;
      status_word_o[`PSM_SW_SETPOINT_ACK] <= setpoint_ack;
      status_word_o[`PSM_SW_TARGET_REACHED] <= target_reached_i;
      error_log_o <= slip_rise && slip_reaction_en_i;
    end
  end

  // object read and write answers, one cycle after the strobe
  reg [31:0] next_rdata;
  reg next_hit;
  reg next_ro;
  always @*
  begin
    next_rdata = 32'h00000000;
    next_hit = 1'b1;
    next_ro = 1'b0;
    case (obj_index_i)
      `PSM_IDX_CONTROL_WORD: next_rdata = {16'h0000, control_word_o};
      `PSM_IDX_STATUS_WORD:
      begin
        next_rdata = {16'h0000, status_word_o};
        next_ro = 1'b1;
      end
      `PSM_IDX_SLIP_TIME: next_rdata = {16'h0000, slip_time};
      `PSM_IDX_OPTION_WORD: next_rdata = {16'h0000, option_word};
      `PSM_IDX_FOLLOW_ERR:
      begin
        next_rdata = follow_err;
        next_ro = 1'b1;
      end
      `PSM_IDX_SLIP_LIMIT: next_rdata = slip_limit;
      `PSM_IDX_CORRECTION:
      begin
        next_rdata = correction;
        next_ro = 1'b1;
      end
      default: next_hit = 1'b0;
    endcase
  end

  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      obj_rdata_o <= 32'h00000000;
      obj_ack_o <= 1'b0;
      obj_err_o <= 1'b0;
    end
    else
    begin
      obj_ack_o <= obj_rd_i || obj_wr_i;
      obj_err_o <= (obj_rd_i && !next_hit) || (obj_wr_i && (!next_hit || next_ro));
      if (obj_rd_i)
        obj_rdata_o <= next_hit ? next_rdata : 32'h00000000;
    end
  end
endmodule // psm_option_core

// ### psm_option_core_assertions.sv
// port checks for the positioning option block
`timescale 1ns/1ps
module psm_option_core_assertions
#(
  parameter TICK_CYCLES = 4
)
(
  // clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // object bus
  input wire obj_wr_i,
  input wire obj_rd_i,
  input wire [15:0] obj_index_i,
  input wire obj_ack_o,
  input wire obj_err_o,
  // handshake and events
  input wire slip_reaction_en_i,
  input wire move_start_o,
  input wire [15:0] control_word_o,
  input wire [15:0] status_word_o,
  input wire error_log_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_ack_after_strobe: assert property ((obj_wr_i || obj_rd_i) |=> obj_ack_o)
    else $error("strobe without ack");
  a_no_stray_ack: assert property (!(obj_wr_i || obj_rd_i) |=> !obj_ack_o)
    else $error("ack without strobe");
  a_err_with_ack: assert property (obj_err_o |-> obj_ack_o)
    else $error("error flag without ack");
  a_ro_write_refused: assert property (obj_wr_i && (obj_index_i == 16'h60f4 || obj_index_i == 16'h60fa) |=> obj_err_o)
    else $error("read-only write accepted");
  a_start_one_cycle: assert property (move_start_o |=> !move_start_o)
    else $error("move start longer than a cycle");
  a_start_sets_ack: assert property (move_start_o |=> status_word_o[12])
    else $error("setpoint ack missing");
  a_ack_follows_release: assert property ($fell(control_word_o[4]) |-> ##2 !status_word_o[12])
    else $error("setpoint ack stays after release");
  a_log_on_rise: assert property ($rose(status_word_o[13]) && slip_reaction_en_i |-> error_log_o)
    else $error("slippage not logged");
  a_log_only_rise: assert property (error_log_o |-> $rose(status_word_o[13]))
    else $error("stray error log");
endmodule // psm_option_core_assertions

bind psm_option_core psm_option_core_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk (.clk_sys_i(clk_sys_i),
  .rst_i(rst_i), .obj_wr_i(obj_wr_i), .obj_rd_i(obj_rd_i), .obj_index_i(obj_index_i), .obj_ack_o(obj_ack_o),
  .obj_err_o(obj_err_o), .slip_reaction_en_i(slip_reaction_en_i), .move_start_o(move_start_o),
  .control_word_o(control_word_o), .status_word_o(status_word_o), .error_log_o(error_log_o));

// ### psm_bus_master.sv
// fieldbus master model: one object read or write per strobe
`timescale 1ns/1ps
module psm_bus_master
(
  // clock
  input wire clk_sys_i,
  // object bus towards the drive
  output reg obj_wr_o,
  output reg obj_rd_o,
  output reg [15:0] obj_index_o,
  output reg [31:0] obj_wdata_o,
  input wire [31:0] obj_rdata_i,
  input wire obj_ack_i,
  input wire obj_err_i
);
  initial
  begin
    obj_wr_o = 1'b0;
    obj_rd_o = 1'b0;
    obj_index_o = 16'h0000;
    obj_wdata_o = 32'h00000000;
  end
  // a missing ack returns an unknown error flag so any compare on it fails
  task xfer(input reg w, input reg [15:0] idx, input reg [31:0] d, output reg [31:0] q, output reg e);
  begin
    @(posedge clk_sys_i);
    #1;
    obj_wr_o = w;
    obj_rd_o = !w;
    obj_index_o = idx;
    obj_wdata_o = d;
    @(posedge clk_sys_i);
    #1;
    q = obj_rdata_i;
    e = obj_ack_i ? obj_err_i : 1'bx;
    obj_wr_o = 1'b0;
    obj_rd_o = 1'b0;
    // released lines show junk, not the last request
    obj_index_o = ~idx;
    obj_wdata_o = ~d;
  end
  endtask
endmodule // psm_bus_master

// ### psm_option_core_test.sv
// self-checking bench for the positioning option block
`timescale 1ns/1ps
module positioning_option_slippage_monitor_test;
  reg clk_sys_i, rst_i, accept, reached, react;
  reg [31:0] tgt, ramp, act_pos, act_spd, set_spd, ferr, corr, q;
  reg e;
  wire wr, rd, ack, err, start, via, elog;
  wire [15:0] idx, cw, sw;
  wire [31:0] wd, rdat, abs_t;
  wire [1:0] dir;
  integer mismatches = 0, n_tests = 0, i;
  psm_bus_master m (.clk_sys_i(clk_sys_i), .obj_wr_o(wr), .obj_rd_o(rd), .obj_index_o(idx), .obj_wdata_o(wd),
    .obj_rdata_i(rdat), .obj_ack_i(ack), .obj_err_i(err));
  psm_option_core #(.TICK_CYCLES(4)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .obj_wr_i(wr), .obj_rd_i(rd),
    .obj_index_i(idx), .obj_wdata_i(wd), .obj_rdata_o(rdat), .obj_ack_o(ack), .obj_err_o(err),
    .target_pos_i(tgt), .ramp_out_i(ramp), .actual_pos_i(act_pos), .range_min_i(32'h00000000),
    .range_max_i(32'h00002710), .setpoint_accept_i(accept), .target_reached_i(reached),
    .actual_speed_i(act_spd), .set_speed_i(set_spd), .following_error_i(ferr), .correction_speed_i(corr),
    .slip_reaction_en_i(react), .abs_target_o(abs_t), .move_start_o(start), .move_dir_o(dir),
    .via_limit_o(via), .control_word_o(cw), .status_word_o(sw), .error_log_o(elog));
  task complete_run;
  begin
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task rd_chk(input [15:0] a, input [31:0] exp, input experr);
  begin
    m.xfer(1'b0, a, 32'h00000000, q, e);
    chk({31'h0, e}, {31'h0, experr});
    if (!experr)
      chk(q, exp);
  end
  endtask
  task wr_obj(input [15:0] a, input [31:0] d, input experr);
  begin
    m.xfer(1'b1, a, d, q, e);
    chk({31'h0, e}, {31'h0, experr});
  end
  endtask
  task wait_start;
  begin
    for (i = 0; i < 20 && start !== 1'b1; i = i + 1)
      @(posedge clk_sys_i) #1;
    if (start !== 1'b1)
    begin
      mismatches = mismatches + 1;
      complete_run;
    end
  end
  endtask
  // setpoint with new-setpoint bit, then the master drops the bit itself
  task move(input [15:0] c, input [31:0] t);
  begin
    tgt = t;
    wr_obj(16'h6040, {16'h0, c | 16'h0010}, 1'b0);
    wait_start;
    wr_obj(16'h6040, {16'h0, c}, 1'b0);
    repeat (3) @(posedge clk_sys_i);
    #1;
  end
  endtask
  task t_objects;
  begin
    rd_chk(16'h60f2, 32'h00000001, 1'b0);
    rd_chk(16'h60f8, 32'h00000190, 1'b0);
    rd_chk(16'h60f4, ferr, 1'b0);
    rd_chk(16'h60fa, corr, 1'b0);
    wr_obj(16'h60f4, 32'h00000001, 1'b1);
    wr_obj(16'h60fa, 32'h00000001, 1'b1);
    rd_chk(16'h1234, 32'h0, 1'b1);
    wr_obj(16'h60f8, 32'h00000123, 1'b0);
    rd_chk(16'h60f8, 32'h00000123, 1'b0);
    wr_obj(16'h60f8, 32'h00000190, 1'b0);
  end
  endtask
  task t_relative;
    reg [31:0] exp [0:2];
    integer k;
  begin
    exp[0] = 32'd105;
    exp[1] = 32'd1005;
    exp[2] = 32'd2005;
    move(16'h0000, 32'd100);
    chk(abs_t, 32'd100);
    for (k = 0; k < 3; k = k + 1)
    begin
      wr_obj(16'h60f2, k, 1'b0);
      move(16'h0040, 32'd5);
      chk(abs_t, exp[k]);
    end
    wr_obj(16'h60f2, 32'h1, 1'b0);
    move(16'h0000, 32'd7);
    chk(abs_t, 32'd7);
  end
  endtask
  task t_direction;
    reg [15:0] opt [0:5];
    reg [31:0] pos [0:5];
    reg [2:0] dv [0:5];
    integer k;
  begin
    opt[0] = 16'h0000; pos[0] = 32'd3000; dv[0] = 3'b010;
    opt[1] = 16'h0040; pos[1] = 32'd3000; dv[1] = 3'b101;
    opt[2] = 16'h0080; pos[2] = 32'd1000; dv[2] = 3'b011;
    opt[3] = 16'h00c0; pos[3] = 32'd3000; dv[3] = 3'b010;
    opt[4] = 16'h00c0; pos[4] = 32'd1000; dv[4] = 3'b100;
    // linear axis: a target past the maximum keeps its full value and passes the limit
    opt[5] = 16'h0000; pos[5] = 32'd12000; dv[5] = 3'b011;
    for (k = 0; k < 6; k = k + 1)
    begin
      wr_obj(16'h60f2, opt[k], 1'b0);
      move(16'h0000, pos[k]);
      chk({dir, via}, dv[k]);
      chk(abs_t, pos[k]);
    end
  end
  endtask
  task t_release;
  begin
    wr_obj(16'h60f2, 32'h0020, 1'b0);
    wr_obj(16'h6040, 32'h0010, 1'b0);
    wait_start;
    repeat (2) @(posedge clk_sys_i) #1;
    chk(cw[4], 1'b0);
    repeat (2) @(posedge clk_sys_i) #1;
    chk(sw[12], 1'b0);
    wr_obj(16'h60f2, 32'h0010, 1'b0);
    wr_obj(16'h6040, 32'h0010, 1'b0);
    wait_start;
    repeat (5) @(posedge clk_sys_i) #1;
    chk(cw[4], 1'b1);
    reached = 1'b1;
    repeat (4) @(posedge clk_sys_i) #1;
    chk(cw[4], 1'b0);
    reached = 1'b0;
  end
  endtask
  task t_slip;
  begin
    wr_obj(16'h203f, 32'h2, 1'b0);
    act_spd = 32'd1500;
    repeat (8) @(posedge clk_sys_i) #1;
    chk(sw[13], 1'b0);
    for (i = 0; i < 20 && sw[13] !== 1'b1; i = i + 1)
      @(posedge clk_sys_i) #1;
    chk(sw[13], 1'b1);
    chk(elog, 1'b1);
    act_spd = 32'd1000;
    repeat (3) @(posedge clk_sys_i) #1;
    chk(sw[13], 1'b0);
    chk(elog, 1'b0);
    wr_obj(16'h60f8, 32'h7fffffff, 1'b0);
    act_spd = 32'd9000;
    repeat (40) @(posedge clk_sys_i) #1;
    chk(sw[13], 1'b0);
  end
  endtask
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    rst_i = 1'b1;
    {accept, reached, react} = 3'b101;
    {tgt, ramp, act_pos} = {32'd0, 32'd1000, 32'd2000};
    {act_spd, set_spd, ferr, corr} = {32'd1000, 32'd1000, 32'hfffffff6, 32'h00000040};
    repeat (4) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    t_objects;
    t_relative;
    t_direction;
    t_release;
    t_slip;
    complete_run;
  end
endmodule // positioning_option_slippage_monitor_test
